// *** hdl/nvmcc_eng_if.sv ***
// Command request and completion between control and engine.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
interface nvmcc_eng_if;
   import nvmcc_pkg::*;
   logic       start;
   nvmcc_cmd_t cmd;
   logic       otp_sel;
   logic [1:0] margin;
   logic       bulk;
   logic [2:0] page;
   logic       done;
   logic       fail;
   logic       busy;
   modport ctrl (output start, cmd, otp_sel, margin, bulk, page,
                 input done, fail, busy);
   modport eng  (input start, cmd, otp_sel, margin, bulk, page,
                 output done, fail, busy);
endinterface

// *** hdl/nvmcc_engine.sv ***
// Command sequencer towards the memory macro handshake.
// Assumes the macro answers op_ack within its own time after op_req.
`timescale 1ns/10ps
module nvmcc_engine
   import nvmcc_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   nrst,
   nvmcc_eng_if.eng    eif,
   input  wire logic   finalised,
   input  wire logic   mem_err,
   input  wire logic   op_ack,
   output logic        op_req
);
   typedef enum logic [1:0] {NVMCC_IDLE, NVMCC_RUN, NVMCC_END} nvmcc_st_t;
   nvmcc_st_t  st_r;
   logic       bad_r;

   // Locked pages and bulk write fail without touching the array
   wire logic  refuse = (eif.cmd == NVMCC_CMD_WRITE) &&
                        (eif.bulk || finalised ||
                         eif.page < 3'h2);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r  <= NVMCC_IDLE;
         bad_r <= 1'b0;
      end else begin
         case (st_r)
            NVMCC_IDLE: begin
               if (eif.start) begin
                  bad_r <= refuse;
                  st_r  <= refuse ? NVMCC_END : NVMCC_RUN;
               end
            end
            NVMCC_RUN: begin
               if (op_ack) begin
                  bad_r <= mem_err;
                  st_r  <= NVMCC_END;
               end
            end
            NVMCC_END: st_r <= NVMCC_IDLE;
            default:   st_r <= NVMCC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst)
         op_req <= 1'b0;
      else
         op_req <= (st_r == NVMCC_IDLE && eif.start && !refuse) ||
                   (st_r == NVMCC_RUN && !op_ack);
   end

   assign eif.done = (st_r == NVMCC_END) && !bad_r;
   assign eif.fail = (st_r == NVMCC_END) && bad_r;
   assign eif.busy = (st_r != NVMCC_IDLE);

   AST_BULK_WRITE_FAILS: assert property (@(posedge clk) disable iff (!nrst)
      (st_r == NVMCC_IDLE && eif.start && eif.cmd == NVMCC_CMD_WRITE &&
       eif.bulk) |=> eif.fail)
      else $error("bulk write did not fail");
endmodule

// *** hdl/nvmcc_pkg.sv ***
// Constants shared by the memory command control block.
// Assumes a 16-bit register port with 16-bit register indices.
package nvmcc_pkg;
   localparam int         ADDR_W          = 16;
   localparam int         DATA_W          = 16;
   localparam logic [15:0] OFS_CMD_CTRL    = 16'h400A;
   localparam logic [15:0] OFS_IRQ_STAT2   = 16'h4012;
   localparam logic [15:0] OFS_IRQ_MASK2   = 16'h401A;
   localparam logic [15:0] OFS_SECURITY    = 16'h4008;
   localparam logic [15:0] OFS_ENG_STAT    = 16'h400C;
   localparam logic [15:0] UNLOCK_CODE     = 16'h9716;
   localparam int         BIT_PROG        = 15;
   localparam int         BIT_MEM         = 13;
   localparam int         BIT_FINAL       = 11;
   localparam int         BIT_VERIFY      = 10;
   localparam int         BIT_WRITE       = 9;
   localparam int         BIT_READ        = 8;
   localparam int         POS_MARGIN      = 6;
   localparam int         BIT_BULK        = 5;
   localparam int         POS_PAGE        = 0;
   localparam int         BIT_DONE        = 5;
   localparam int         BIT_FAIL        = 4;
   localparam logic [15:0] CTRL_RESET      = 16'h2000;
   localparam logic [15:0] CTRL_WMASK      = 16'h2FE3;
   localparam logic       MASK_RESET      = 1'b1;
   localparam int         CLK_MHZ         = 50;
   localparam int         OP_TIME_NS      = 200;
   localparam int         OP_CYCLES       = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [1:0] {
      NVMCC_CMD_READ,
      NVMCC_CMD_WRITE,
      NVMCC_CMD_VERIFY,
      NVMCC_CMD_FINAL
   } nvmcc_cmd_t;
endpackage

// *** hdl/nvmcc_top.sv ***
// Command control register, flags and interrupt for the config memories.
// Assumes a same-clock register port; memory handshake from the macro.
//
// Overview of operation
// - Writing one enters program state until reset
// - Source bit: zero external, one OTP; resets one
// - Finalise bit starts finalise, locking OTP writes
// - Verify bit starts verify of selected pages
// - Write bit starts programming of selected pages
// - Read bit starts read from chosen memory
// - Margin field selects read margin for OTP
// - Bulk bit: zero single page, one all
// - OTP page codes map to pages zero-three
// - External page codes map to two-five, reserved
// - Protected fields change only after unlock code
// - Done flag set on command or autoprogram end
// - Fail flag on read, verify or locked-write error
// - Flags set on rising edge, cleared writing one
// - Unmasked flags drive the primary interrupt
// - Mask one keeps flag off the interrupt; masks reset to one
// - Commands accepted only in program state
// - Bulk OTP write signals command fail
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module nvmcc_top
   import nvmcc_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic [ADDR_W-1:0]  reg_addr,
   input  wire logic [DATA_W-1:0]  reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [DATA_W-1:0]  reg_rdata,
   input  wire logic               auto_prog_done,
   input  wire logic               ext_mem_err,
   input  wire logic               mem_op_ack,
   input  wire logic               otp_finalised,
   output logic                    mem_op_req,
   output logic                    mem_otp_sel,
   output logic      [1:0]         mem_margin,
   output logic                    mem_bulk,
   output logic      [2:0]         mem_page,
   output logic      [1:0]         mem_cmd,
   output logic                    program_state,
   output logic                    mem_irq
);
   nvmcc_eng_if eif ();

   logic [DATA_W-1:0] ctrl_r;
   logic              prog_r;
   logic              unlock_r;
   logic              done_flag_r;
   logic              fail_flag_r;
   logic              done_mask_r;
   logic              fail_mask_r;
   logic              done_ev_r;
   logic              fail_ev_r;
   logic              auto_s1_r;
   logic              auto_s2_r;
   logic              err_s1_r;
   logic              err_s2_r;
   logic              ack_s1_r;
   logic              ack_s2_r;
   logic              fin_s1_r;
   logic              fin_s2_r;
   logic              auto_d_r;
   logic              start_r;
   nvmcc_cmd_t        cmd_r;
   logic              otp_sel_r;
   logic [1:0]        margin_r;
   logic              bulk_r;
   logic [2:0]        page_r;
   logic              pending_r;
   logic              op_req_w;

   wire logic wr_ctrl  = reg_wr && reg_addr == OFS_CMD_CTRL;
   wire logic wr_stat  = reg_wr && reg_addr == OFS_IRQ_STAT2;
   wire logic wr_mask  = reg_wr && reg_addr == OFS_IRQ_MASK2;
   wire logic wr_sec   = reg_wr && reg_addr == OFS_SECURITY;
   wire logic [3:0] cmd_bits = {reg_wdata[BIT_FINAL], reg_wdata[BIT_VERIFY],
                                reg_wdata[BIT_WRITE], reg_wdata[BIT_READ]};
   // A new command waits for the last one; back-to-back writes are dropped
   wire logic cmd_go   = wr_ctrl && unlock_r && prog_r && !pending_r &&
                         (cmd_bits != 4'h0);

   // Outside signals cross in two stages before use
   always_ff @(posedge clk) begin
      if (!nrst) begin
         {auto_s1_r, auto_s2_r, err_s1_r, err_s2_r} <= 4'h0;
         {ack_s1_r, ack_s2_r, fin_s1_r, fin_s2_r}   <= 4'h0;
      end else begin
         auto_s1_r <= auto_prog_done;
         auto_s2_r <= auto_s1_r;
         err_s1_r  <= ext_mem_err;
         err_s2_r  <= err_s1_r;
         ack_s1_r  <= mem_op_ack;
         ack_s2_r  <= ack_s1_r;
         fin_s1_r  <= otp_finalised;
         fin_s2_r  <= fin_s1_r;
      end
   end

   // Unlock held until reset or a security write of another value; key register itself is not modelled
   always_ff @(posedge clk) begin
      if (!nrst)
         unlock_r <= 1'b0;
      else if (wr_sec)
         unlock_r <= (reg_wdata == UNLOCK_CODE);
   end

   // Sticky: only reset leaves program state
   always_ff @(posedge clk) begin
      if (!nrst)
         prog_r <= 1'b0;
      else if (wr_ctrl && reg_wdata[BIT_PROG])
         prog_r <= 1'b1;
   end

   // Command bits self-clear once the command is launched
   always_ff @(posedge clk) begin
      if (!nrst)
         ctrl_r <= CTRL_RESET;
      else if (wr_ctrl && unlock_r && !pending_r)
         ctrl_r <= reg_wdata & CTRL_WMASK;
      else if (start_r)
         ctrl_r <= ctrl_r & ~(16'h0F00);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         start_r   <= 1'b0;
         pending_r <= 1'b0;
         cmd_r     <= NVMCC_CMD_READ;
         otp_sel_r <= 1'b1;
         margin_r  <= 2'h0;
         bulk_r    <= 1'b0;
         page_r    <= 3'h0;
      end else begin
         start_r <= cmd_go;
         if (cmd_go) begin
            pending_r <= 1'b1;
            // Fields frozen for the whole command
            otp_sel_r <= reg_wdata[BIT_MEM];
            margin_r  <= reg_wdata[POS_MARGIN +: 2];
            bulk_r    <= reg_wdata[BIT_BULK];
            // Page decode differs by source memory
            page_r    <= reg_wdata[BIT_MEM] ?
                         {1'b0, reg_wdata[POS_PAGE +: 2]} :
                         3'(reg_wdata[POS_PAGE +: 2]) + 3'h2;
            // One command per write; finalise has top priority
            if (reg_wdata[BIT_FINAL])
               cmd_r <= NVMCC_CMD_FINAL;
            else if (reg_wdata[BIT_VERIFY])
               cmd_r <= NVMCC_CMD_VERIFY;
            else if (reg_wdata[BIT_WRITE])
               cmd_r <= NVMCC_CMD_WRITE;
            else
               cmd_r <= NVMCC_CMD_READ;
         end else if (eif.done || eif.fail) begin
            pending_r <= 1'b0;
         end
      end
   end

   assign eif.start   = start_r;
   assign eif.cmd     = cmd_r;
   assign eif.otp_sel = otp_sel_r;
   assign eif.margin  = margin_r;
   assign eif.bulk    = bulk_r;
   assign eif.page    = page_r;

   // Memory errors count on every acknowledged command, whatever the source memory
   nvmcc_engine u_eng (
      .clk       (clk),
      .nrst      (nrst),
      .eif       (eif),
      .finalised (fin_s2_r),
      .mem_err   (err_s2_r),
      .op_ack    (ack_s2_r),
      .op_req    (op_req_w)
   );

   // Event levels, edge detected below
   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_ev_r <= 1'b0;
         fail_ev_r <= 1'b0;
         auto_d_r  <= 1'b0;
      end else begin
         done_ev_r <= eif.done;
         fail_ev_r <= eif.fail;
         auto_d_r  <= auto_s2_r;
      end
   end

   wire logic done_rise = (eif.done && !done_ev_r) ||
                          (auto_s2_r && !auto_d_r);
   wire logic fail_rise = eif.fail && !fail_ev_r;

   // Set beats a simultaneous write-one clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_flag_r <= 1'b0;
         fail_flag_r <= 1'b0;
      end else begin
         done_flag_r <= done_rise ||
            (done_flag_r && !(wr_stat && reg_wdata[BIT_DONE]));
         fail_flag_r <= fail_rise ||
            (fail_flag_r && !(wr_stat && reg_wdata[BIT_FAIL]));
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_mask_r <= MASK_RESET;
         fail_mask_r <= MASK_RESET;
      end else if (wr_mask) begin
         done_mask_r <= reg_wdata[BIT_DONE];
         fail_mask_r <= reg_wdata[BIT_FAIL];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst)
         mem_irq <= 1'b0;
      else
         mem_irq <= (done_flag_r && !done_mask_r) ||
                    (fail_flag_r && !fail_mask_r);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         mem_op_req    <= 1'b0;
         mem_otp_sel   <= 1'b1;
         mem_margin    <= 2'h0;
         mem_bulk      <= 1'b0;
         mem_page      <= 3'h0;
         mem_cmd       <= 2'h0;
         program_state <= 1'b0;
      end else begin
         mem_op_req    <= op_req_w;
         mem_otp_sel   <= otp_sel_r;
         mem_margin    <= margin_r;
         mem_bulk      <= bulk_r;
         mem_page      <= page_r;
         mem_cmd       <= cmd_r;
         program_state <= prog_r;
      end
   end

   // Unmapped addresses read as zero
   always_ff @(posedge clk) begin
      if (!nrst)
         reg_rdata <= '0;
      else if (reg_rd) begin
         case (reg_addr)
            OFS_CMD_CTRL:  reg_rdata <= ctrl_r | (16'(prog_r) << BIT_PROG);
            OFS_IRQ_STAT2: reg_rdata <= (16'(done_flag_r) << BIT_DONE) |
                                        (16'(fail_flag_r) << BIT_FAIL);
            OFS_IRQ_MASK2: reg_rdata <= (16'(done_mask_r) << BIT_DONE) |
                                        (16'(fail_mask_r) << BIT_FAIL);
            OFS_ENG_STAT:  reg_rdata <= {13'h0, unlock_r, pending_r, prog_r};
            default:       reg_rdata <= '0;
         endcase
      end else
         reg_rdata <= '0;
   end

   sequence s_clear_done;
      wr_stat && reg_wdata[BIT_DONE] && !done_rise;
   endsequence

   AST_PROG_STICKY: assert property (@(posedge clk) disable iff (!nrst)
      prog_r |=> prog_r)
      else $error("program state left without reset");
   AST_NO_CMD_OUTSIDE_PROG: assert property (@(posedge clk) disable iff (!nrst)
      !prog_r |=> !start_r)
      else $error("command started outside program state");
   AST_LOCKED_CTRL: assert property (@(posedge clk) disable iff (!nrst)
      (wr_ctrl && !unlock_r) |=> $stable(ctrl_r))
      else $error("protected field changed while locked");
   AST_DONE_SET: assert property (@(posedge clk) disable iff (!nrst)
      done_rise |=> done_flag_r)
      else $error("done flag missed");
   AST_FAIL_SET: assert property (@(posedge clk) disable iff (!nrst)
      fail_rise |=> fail_flag_r)
      else $error("fail flag missed");
   AST_DONE_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
      s_clear_done |=> !done_flag_r)
      else $error("done flag not cleared");
   AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!nrst)
      (fail_flag_r && !fail_mask_r) |=> mem_irq)
      else $error("unmasked flag gave no interrupt");
   AST_MASK_BLOCK: assert property (@(posedge clk) disable iff (!nrst)
      (done_mask_r && fail_mask_r) |=> !mem_irq)
      else $error("masked flags raised interrupt");
   AST_FIELDS_HELD: assert property (@(posedge clk) disable iff (!nrst)
      (pending_r && !cmd_go) |=> $stable(page_r) && $stable(cmd_r))
      else $error("fields moved during command");
   AST_EXT_PAGE: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_go && !reg_wdata[BIT_MEM] && reg_wdata[1:0] == 2'h0)
      |=> page_r == 3'h2)
      else $error("external page decode wrong");
endmodule

// *** verification/nvmcc_tb.sv ***
// Self-checking bench for the memory command control block.
// Assumes nvmcc_top alone; the bench plays both host and memory macro.
`timescale 1ns/10ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin \
   fail_count++; $display("wrong value at %0t: %s", $time, m); end end
module tb;
   import nvmcc_pkg::*;
   logic              clk;
   logic              nrst;
   logic [15:0]       reg_addr;
   logic [15:0]       reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [15:0]       reg_rdata;
   logic              auto_prog_done;
   logic              ext_mem_err;
   logic              mem_op_ack;
   logic              otp_finalised;
   logic              mem_op_req;
   logic              mem_otp_sel;
   logic [1:0]        mem_margin;
   logic              mem_bulk;
   logic [2:0]        mem_page;
   logic [1:0]        mem_cmd;
   logic              program_state;
   logic              mem_irq;
   logic [15:0]       d;
   logic [15:0]       mask_v;
   int                fail_count;
   int                n_tests;

   nvmcc_top dut_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .auto_prog_done(auto_prog_done),
      .ext_mem_err(ext_mem_err), .mem_op_ack(mem_op_ack),
      .otp_finalised(otp_finalised), .mem_op_req(mem_op_req),
      .mem_otp_sel(mem_otp_sel), .mem_margin(mem_margin),
      .mem_bulk(mem_bulk), .mem_page(mem_page), .mem_cmd(mem_cmd),
      .program_state(program_state), .mem_irq(mem_irq));

   always #10 clk = ~clk;

   task finish_test;
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task end_test(input string name);
      $display("test %s done", name);
   endtask

   task wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // Data is only valid in the cycle after the strobe
   task rd(input logic [15:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   task wait_req(input logic lvl);
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if (mem_op_req === lvl)
            break;
      end
      `CHK(mem_op_req, lvl, "op request level")
   endtask

   // Launch, check latched fields, answer, then check and clear flags
   task run(input logic [15:0] v, input logic err, input logic [1:0] cmd,
            input logic sel, input logic [1:0] mg, input logic [2:0] pg);
      wr(OFS_CMD_CTRL, v);
      wait_req(1'b1);
      `CHK(mem_cmd, cmd, "latched command")
      `CHK(mem_otp_sel, sel, "latched source")
      `CHK(mem_margin, mg, "latched margin")
      `CHK(mem_bulk, v[BIT_BULK], "latched bulk")
      if (!v[BIT_BULK])
         `CHK(mem_page, pg, "latched page")
      // A second command while pending must not disturb the fields
      wr(OFS_CMD_CTRL, 16'h0120);
      `CHK(mem_otp_sel, sel, "source held while pending")
      `CHK(mem_cmd, cmd, "command held while pending")
      @(posedge clk);
      mem_op_ack  <= 1'b1;
      ext_mem_err <= err;
      wait_req(1'b0);
      @(posedge clk);
      mem_op_ack  <= 1'b0;
      ext_mem_err <= 1'b0;
      repeat (4) @(posedge clk);
      rd(OFS_IRQ_STAT2, d);
      if (err)
         `CHK(d[BIT_FAIL], 1'b1, "fail flag")
      else
         `CHK(d, 16'h0020, "done flag only")
      `CHK(mem_irq, err ? !mask_v[4] : !mask_v[5], "irq level")
      rd(OFS_CMD_CTRL, d);
      `CHK(d, (v & 16'hF0FF) | 16'h8000, "ctrl readback")
      wr(OFS_IRQ_STAT2, 16'h0030);
      repeat (3) @(posedge clk);
      `CHK(mem_irq, 1'b0, "irq after clear")
   endtask

   // Refused writes fail at once with no macro operation
   task fail_now(input logic [15:0] v);
      wr(OFS_CMD_CTRL, v);
      repeat (6) @(posedge clk);
      #1;
      `CHK(mem_op_req, 1'b0, "no op on refused write")
      rd(OFS_IRQ_STAT2, d);
      `CHK(d[BIT_FAIL], 1'b1, "fail on refused write")
      wr(OFS_IRQ_STAT2, 16'h0030);
   endtask

   initial begin
      #200000;
      fail_count++;
      finish_test;
   end

   initial begin
      clk = 0;
      nrst = 0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      reg_wr = 0;
      reg_rd = 0;
      auto_prog_done = 0;
      ext_mem_err = 0;
      mem_op_ack = 0;
      otp_finalised = 0;
      mask_v = 16'h0030;
      fail_count = 0;
      n_tests = 0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_CMD_CTRL, d);
      `CHK(d, 16'h2000, "ctrl reset value")
      rd(OFS_IRQ_MASK2, d);
      `CHK(d, 16'h0030, "mask reset value")
      rd(OFS_IRQ_STAT2, d);
      `CHK(d, 16'h0000, "status reset value")
      rd(16'h4000, d);
      `CHK(d, 16'h0000, "unmapped read")
      `CHK(program_state, 1'b0, "program state at reset")
      `CHK(mem_otp_sel, 1'b1, "source at reset")
      end_test("reset");
      wr(OFS_CMD_CTRL, 16'h0000);
      rd(OFS_CMD_CTRL, d);
      `CHK(d, 16'h2000, "locked write ignored")
      wr(OFS_SECURITY, UNLOCK_CODE);
      wr(OFS_CMD_CTRL, 16'h2202);
      repeat (10) @(posedge clk);
      `CHK(mem_op_req, 1'b0, "no command outside program state")
      wr(OFS_CMD_CTRL, 16'h8000);
      repeat (2) @(posedge clk);
      `CHK(program_state, 1'b1, "program state entered")
      wr(OFS_CMD_CTRL, 16'h2000);
      repeat (2) @(posedge clk);
      `CHK(program_state, 1'b1, "zero keeps program state")
      rd(OFS_ENG_STAT, d);
      `CHK(d, 16'h0005, "unlocked, idle, program state")
      end_test("lock and program");
      run(16'h2120, 0, 2'h0, 1'b1, 2'h0, 3'h0);
      run(16'h0100, 0, 2'h0, 1'b0, 2'h0, 3'h2);
      run(16'h0101, 0, 2'h0, 1'b0, 2'h0, 3'h3);
      run(16'h0102, 0, 2'h0, 1'b0, 2'h0, 3'h4);
      run(16'h2100, 0, 2'h0, 1'b1, 2'h0, 3'h0);
      run(16'h2483, 0, 2'h2, 1'b1, 2'h2, 3'h3);
      run(16'h24C1, 0, 2'h2, 1'b1, 2'h3, 3'h1);
      run(16'h2202, 0, 2'h1, 1'b1, 2'h0, 3'h2);
      run(16'h2802, 0, 2'h3, 1'b1, 2'h0, 3'h2);
      end_test("commands");
      run(16'h0101, 1, 2'h0, 1'b0, 2'h0, 3'h3);
      fail_now(16'h2220);
      fail_now(16'h2201);
      otp_finalised <= 1'b1;
      fail_now(16'h2203);
      otp_finalised <= 1'b0;
      end_test("errors");
      mask_v = 16'h0010;
      wr(OFS_IRQ_MASK2, mask_v);
      run(16'h2100, 0, 2'h0, 1'b1, 2'h0, 3'h0);
      mask_v = 16'h0020;
      wr(OFS_IRQ_MASK2, mask_v);
      run(16'h2483, 1, 2'h2, 1'b1, 2'h2, 3'h3);
      mask_v = 16'h0010;
      wr(OFS_IRQ_MASK2, mask_v);
      auto_prog_done <= 1'b1;
      repeat (6) @(posedge clk);
      rd(OFS_IRQ_STAT2, d);
      `CHK(d, 16'h0020, "done on auto program")
      `CHK(mem_irq, 1'b1, "irq on auto program")
      // Level still high: a clear must stick without a new edge
      wr(OFS_IRQ_STAT2, 16'h0020);
      repeat (4) @(posedge clk);
      rd(OFS_IRQ_STAT2, d);
      `CHK(d, 16'h0000, "edge triggered flag")
      auto_prog_done <= 1'b0;
      end_test("interrupts");
      @(posedge clk);
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_IRQ_MASK2, d);
      `CHK(d, 16'h0030, "mask after reset")
      `CHK(program_state, 1'b0, "reset leaves program state")
      end_test("second reset");
      finish_test;
   end
endmodule
